// File: include/sfcfe_pkg.sv
// Constants, types and decode helpers for the serial flash command front end
package sfcfe_pkg;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_VSR_WREN = 8'h50;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_DEV_ID = 8'hab;
    localparam logic [7:0] OP_MFR_DEV = 8'h90;
    localparam logic [7:0] OP_MFR_DEV2 = 8'h92;
    localparam logic [7:0] OP_MFR_DEV4 = 8'h94;
    localparam logic [7:0] OP_JEDEC = 8'h9f;
    localparam logic [7:0] OP_UID = 8'h4b;
    localparam logic [7:0] OP_READ3 = 8'h03;
    localparam logic [7:0] OP_READ4 = 8'h13;
    localparam logic [7:0] OP_FREAD3 = 8'h0b;
    localparam logic [7:0] OP_FREAD4 = 8'h0c;
    localparam logic [7:0] OP_PROG3 = 8'h02;
    localparam logic [7:0] OP_PROG4 = 8'h12;
    localparam logic [7:0] OP_SE3 = 8'h20;
    localparam logic [7:0] OP_SE4 = 8'h21;
    localparam logic [7:0] OP_BE32 = 8'h52;
    localparam logic [7:0] OP_BE64 = 8'hd8;
    localparam logic [7:0] OP_BE64_4 = 8'hdc;
    localparam logic [7:0] OP_CE_A = 8'hc7;
    localparam logic [7:0] OP_CE_B = 8'h60;
    localparam logic [7:0] OP_RDSR1 = 8'h05;
    localparam logic [7:0] OP_RDSR2 = 8'h35;
    localparam logic [7:0] OP_RDSR3 = 8'h15;
    localparam logic [7:0] OP_WRSR1 = 8'h01;
    localparam logic [7:0] OP_WRSR2 = 8'h31;
    localparam logic [7:0] OP_WRSR3 = 8'h11;
    localparam logic [7:0] OP_ENTER4 = 8'hb7;
    localparam logic [7:0] OP_EXIT4 = 8'he9;
    localparam logic [7:0] OP_RST_EN = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99;
    localparam logic [7:0] OP_PWR_DOWN = 8'hb9;
    localparam logic [7:0] OP_WR_UPPER = 8'hc5;
    localparam logic [7:0] OP_RD_UPPER = 8'hc8;
    localparam logic [7:0] OP_LOCK_ALL = 8'h7e;
    localparam logic [7:0] OP_UNLOCK_ALL = 8'h98;
    // Status bit positions
    localparam int SR1_BUSY = 0;
    localparam int SR1_WEL = 1;
    localparam int SR3_ADDR_WIDTH = 0;
    localparam int SR3_PWRUP_DEFAULT = 1;
    localparam int SR3_LOCK_SELECT = 2;
    localparam logic [7:0] SR_WR_MASK1 = 8'hfc;
    localparam logic [7:0] SR_WR_MASK3 = 8'hfc;
    localparam logic [7:0] SR_RESET = 8'h00;
    localparam logic [7:0] UPPER_RESET = 8'h00;
    // Byte index of the first answer byte for the identification reads
    localparam logic [3:0] ID_DATA_START = 4'd4;
    localparam logic [3:0] UID_DATA_START = 4'd5;
    localparam logic [3:0] UID_DATA_LAST = 4'd12;
    localparam int BLOCK_LSB = 16;
    // Internal cycle time and its count at 200 MHz, rounded up
    localparam int CLK_PERIOD_PS = 5000;
    localparam int BUSY_TIME_NS = 1000;
    localparam int BUSY_CYCLES = (BUSY_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef enum logic [2:0] {
        SFCFE_PROG, SFCFE_ERASE_4K, SFCFE_ERASE_32K, SFCFE_ERASE_64K, SFCFE_ERASE_ALL
    } sfcfe_kind_t;

    typedef struct packed {
        sfcfe_kind_t kind;
        logic [31:0] addr;
    } sfcfe_array_cmd_t;

    typedef struct packed {
        logic [7:0] sr1;
        logic [7:0] sr2;
        logic [7:0] sr3;
        logic [7:0] upper;
        logic power_down;
    } sfcfe_view_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] first_addr;
        logic [7:0] last_data;
        logic [31:0] addr;
        logic [3:0] bytes;
        logic aligned;
    } sfcfe_frame_t;

    // Number of true address bytes after the opcode
    function automatic logic [3:0] sfcfe_addr_bytes(input logic [7:0] op, input logic four);
        case (op)
            OP_READ3, OP_FREAD3, OP_PROG3, OP_SE3, OP_BE32, OP_BE64:
                sfcfe_addr_bytes = four ? 4'd4 : 4'd3;
            OP_READ4, OP_FREAD4, OP_PROG4, OP_SE4, OP_BE64_4:
                sfcfe_addr_bytes = 4'd4;
            default:
                sfcfe_addr_bytes = 4'd0;
        endcase
    endfunction

    // Byte index at which data in or out begins
    function automatic logic [3:0] sfcfe_data_start(input logic [7:0] op, input logic four);
        case (op)
            OP_DEV_ID, OP_MFR_DEV, OP_MFR_DEV2, OP_MFR_DEV4:
                sfcfe_data_start = ID_DATA_START;
            OP_UID:
                sfcfe_data_start = UID_DATA_START;
            OP_FREAD3, OP_FREAD4:
                sfcfe_data_start = 4'd2 + sfcfe_addr_bytes(op, four);
            default:
                sfcfe_data_start = 4'd1 + sfcfe_addr_bytes(op, four);
        endcase
    endfunction
endpackage

// File: rtl/sfcfe_top.sv
// Serial flash command front end: link framing, decode and volatile state
//
// Behaviour
// - Block locks protect only while the lock-select bit is 1.
// - Every block lock bit is 1 after power-up.
// - Upper address byte supplies bits 31..24 only in 3-byte addressing.
// - Bit 24 from that byte picks lower or upper 16 MB half.
// - Strap high or B7h makes all address commands take four address bytes.
// - Any 4-byte address overwrites the upper address byte with its top byte.
// - Upper address byte clears at power-up, software reset and hardware reset.
// - First byte after chip select falls is the opcode.
// - Input sampled on rising serial clock edges, most significant bit first.
// - Reads may end after any bit; output simply stops.
// - Write, program, erase frames not ending on a byte boundary are discarded.
// - While busy only status-register reads are honoured.
// - Identification opcodes return maker code and device codes; ABh returns the device code only.
// - 06h, 50h set latches, 04h clears both; ABh alone leaves power-down.
// - 4Bh takes four dummy bytes then shifts out 64-bit identifier.
// - 03h/13h read directly after address; 0Bh/0Ch take one dummy byte.
// - 02h/12h page program with three or four address bytes plus data.
// - 20h/21h sector erase with three or four address bytes, no data.
// - 52h, D8h, DCh block erases of 32 KB and 64 KB.
// - C7h or 60h erase the whole array, no address.
// - Three status registers read by 05h/35h/15h, written by 01h/31h/11h.
`timescale 1ns/10ps
module sfcfe_top
    import sfcfe_pkg::*;
#(
    parameter int NUM_BLOCKS = 512,
    parameter logic [7:0] MAKER_CODE = 8'h5a,
    parameter logic [7:0] DEVICE_CODE8 = 8'h3c,
    parameter logic [15:0] DEVICE_CODE16 = 16'h1234,
    parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_out_oe,
    input wire logic addr_width_powerup_default,
    output logic [31:0] array_rd_addr,
    input wire logic [7:0] array_rd_data,
    output logic prog_byte_valid,
    output logic [7:0] prog_byte,
    output logic array_cmd_valid,
    output sfcfe_array_cmd_t array_cmd,
    output logic [7:0] upper_address_byte
);
    // Link domain state
    logic [2:0] bit_cnt_reg;
    logic [3:0] byte_cnt_reg;
    logic [6:0] shift_reg;
    sfcfe_frame_t frame_reg;
    logic [31:0] rd_addr_reg;
    logic [7:0] prog_byte_reg;
    logic prog_valid_reg;
    logic [7:0] out_reg;
    logic drive_reg;
    sfcfe_view_t view_s1_reg;
    sfcfe_view_t view_s2_reg;

    // System domain state
    logic cs_s1_reg;
    logic cs_s2_reg;
    logic cs_prev_reg;
    logic strap_s1_reg;
    logic strap_s2_reg;
    logic [7:0] sr1_reg;
    logic [7:0] sr2_reg;
    logic [7:0] sr3_reg;
    logic [7:0] upper_reg;
    logic wel_reg;
    logic vwe_reg;
    logic pd_reg;
    logic rst_en_reg;
    logic [NUM_BLOCKS-1:0] lock_reg;
    logic [15:0] busy_cnt_reg;
    logic cmd_valid_reg;
    sfcfe_array_cmd_t cmd_reg;

    // Link side decode
    wire [7:0] in_byte = {shift_reg, serial_data_in};
    wire byte_done = (bit_cnt_reg == 3'd7);
    wire [3:0] byte_cnt_next = (byte_cnt_reg == 4'hf) ? byte_cnt_reg : byte_cnt_reg + 4'd1;
    wire l_four = view_s2_reg.sr3[SR3_ADDR_WIDTH];
    wire l_busy = view_s2_reg.sr1[SR1_BUSY];
    wire [7:0] l_op = frame_reg.opcode;
    wire [3:0] l_alen = sfcfe_addr_bytes(l_op, l_four);
    wire [3:0] l_dstart = sfcfe_data_start(l_op, l_four);
    wire l_in_addr = (byte_cnt_reg != 4'd0) && (byte_cnt_reg <= (|l_alen ? l_alen : 4'd3));
    wire [31:0] l_addr_new = l_in_addr ? {frame_reg.addr[23:0], in_byte} : frame_reg.addr;
    wire l_sr_read = (l_op == OP_RDSR1) || (l_op == OP_RDSR2) || (l_op == OP_RDSR3);
    wire l_prog = (l_op == OP_PROG3) || (l_op == OP_PROG4);
    wire l_read = (l_op == OP_READ3) || (l_op == OP_READ4)
        || (l_op == OP_FREAD3) || (l_op == OP_FREAD4);
    wire l_id = (l_op == OP_DEV_ID) || (l_op == OP_MFR_DEV)
        || (l_op == OP_MFR_DEV2) || (l_op == OP_MFR_DEV4);

    wire l_ignored = (l_busy && !l_sr_read)
        || (view_s2_reg.power_down && (l_op != OP_DEV_ID));

    wire [31:0] l_base = (l_alen == 4'd4) ? l_addr_new : {view_s2_reg.upper, l_addr_new[23:0]};

    always_ff @(posedge sck or posedge cs_n)
    begin
        if (cs_n)
        begin
            bit_cnt_reg <= 3'd0;
            byte_cnt_reg <= 4'd0;
            shift_reg <= 7'h00;
            prog_valid_reg <= 1'b0;
        end
        else
        begin
            bit_cnt_reg <= bit_cnt_reg + 3'd1;
            shift_reg <= in_byte[6:0];
            if (byte_done)
            begin
                byte_cnt_reg <= byte_cnt_next;
            end
            prog_valid_reg <= byte_done && l_prog && !l_ignored && (byte_cnt_reg >= l_dstart);
        end
    end

    // Frame fields hold across chip select high so the system side can read them
    always_ff @(posedge sck)
    begin
        frame_reg.aligned <= byte_done;
        if (byte_done)
        begin
            frame_reg.bytes <= byte_cnt_next;
            frame_reg.addr <= l_addr_new;
            prog_byte_reg <= in_byte;
            if (byte_cnt_reg == 4'd0)
            begin
                frame_reg.opcode <= in_byte;
            end
            if (byte_cnt_reg == 4'd1)
            begin
                frame_reg.first_addr <= in_byte;
            end
            if (byte_cnt_reg >= l_dstart)
            begin
                frame_reg.last_data <= in_byte;
            end
            // read address after address and dummy
            if (byte_cnt_next == l_dstart)
            begin
                rd_addr_reg <= l_base;
            end
            else if (byte_cnt_next > l_dstart)
            begin
                rd_addr_reg <= rd_addr_reg + 32'd1;
            end
        end
        view_s1_reg <= sfcfe_view_t'({sr1_reg[7:2], wel_reg, busy_cnt_reg != 16'd0,
            sr2_reg, sr3_reg, upper_reg, pd_reg});
        view_s2_reg <= view_s1_reg;
    end

    // Answer byte for the byte slot now starting
    wire [3:0] k = byte_cnt_reg;
    wire [63:0] uid_shift = UNIQUE_ID << {(k - UID_DATA_START), 3'b000};
    wire id_pick = k[0] ^ frame_reg.addr[0];
    logic [7:0] tx_byte;
    logic tx_valid;

    always_comb
    begin
        tx_byte = 8'h00;
        tx_valid = (k >= l_dstart) && !l_ignored;
        case (l_op)
            OP_RDSR1: tx_byte = view_s2_reg.sr1;
            OP_RDSR2: tx_byte = view_s2_reg.sr2;
            OP_RDSR3: tx_byte = view_s2_reg.sr3;
            OP_RD_UPPER: tx_byte = view_s2_reg.upper;
            OP_JEDEC:
            begin
                tx_byte = (k == 4'd1) ? MAKER_CODE
                    : (k == 4'd2) ? DEVICE_CODE16[15:8] : DEVICE_CODE16[7:0];
                tx_valid = tx_valid && (k <= 4'd3);
            end
            OP_UID:
            begin
                tx_byte = uid_shift[63:56];
                tx_valid = tx_valid && (k <= UID_DATA_LAST);
            end
            default:
            begin
                if (l_op == OP_DEV_ID)
                begin
                    tx_byte = DEVICE_CODE8;
                end
                else if (l_id)
                begin
                    tx_byte = id_pick ? DEVICE_CODE8 : MAKER_CODE;
                end
                else
                begin
                    tx_byte = array_rd_data;
                end
                tx_valid = tx_valid && (l_id || l_read);
            end
        endcase
    end

    always_ff @(negedge sck or posedge cs_n)
    begin
        if (cs_n)
        begin
            out_reg <= 8'h00;
            drive_reg <= 1'b0;
        end
        else if (bit_cnt_reg == 3'd0 && byte_cnt_reg != 4'd0)
        begin
            out_reg <= tx_byte;
            drive_reg <= tx_valid;
        end
        else
        begin
            out_reg <= {out_reg[6:0], 1'b0};
        end
    end

    assign serial_data_out = out_reg[7];
    assign serial_data_out_oe = drive_reg && !cs_n;
    assign array_rd_addr = rd_addr_reg;
    assign prog_byte_valid = prog_valid_reg;
    assign prog_byte = prog_byte_reg;

    // System side decode of the finished frame
    wire frame_end = cs_s2_reg && !cs_prev_reg;
    wire [7:0] op = frame_reg.opcode;
    wire [3:0] nbytes = frame_reg.bytes;
    wire busy = (busy_cnt_reg != 16'd0);
    wire four = sr3_reg[SR3_ADDR_WIDTH];
    wire [3:0] alen = sfcfe_addr_bytes(op, four);
    wire [31:0] full_addr = (alen == 4'd4) ? frame_reg.addr : {upper_reg, frame_reg.addr[23:0]};
    wire [8:0] blk = full_addr[BLOCK_LSB+8:BLOCK_LSB];
    wire is_prog = (op == OP_PROG3) || (op == OP_PROG4);
    wire is_chip = (op == OP_CE_A) || (op == OP_CE_B);
    wire is_erase = (op == OP_SE3) || (op == OP_SE4) || (op == OP_BE32)
        || (op == OP_BE64) || (op == OP_BE64_4);
    wire is_wrsr = (op == OP_WRSR1) || (op == OP_WRSR2) || (op == OP_WRSR3);
    wire lock_hit = sr3_reg[SR3_LOCK_SELECT] && (is_chip ? |lock_reg : lock_reg[blk]);
    wire accept = frame_end && (nbytes != 4'd0) && !busy && (!pd_reg || op == OP_DEV_ID);
    wire wr_ok = accept && frame_reg.aligned;
    wire single = wr_ok && (nbytes == 4'd1);
    wire arr_go = wr_ok && wel_reg && !lock_hit
        && ((is_prog && nbytes > alen + 4'd1)
        || (is_erase && nbytes == alen + 4'd1)
        || (is_chip && nbytes == 4'd1));
    wire sr_go = wr_ok && is_wrsr && (wel_reg || vwe_reg) && (nbytes == 4'd2);
    wire upper_load = accept && (alen == 4'd4) && (nbytes >= 4'd2);
    wire soft_rst = single && (op == OP_RST) && rst_en_reg;
    sfcfe_kind_t kind;
    assign kind = is_prog ? SFCFE_PROG
        : is_chip ? SFCFE_ERASE_ALL
        : (op == OP_SE3 || op == OP_SE4) ? SFCFE_ERASE_4K
        : (op == OP_BE32) ? SFCFE_ERASE_32K : SFCFE_ERASE_64K;

    // Chip select and strap cross through two flops
    always_ff @(posedge clk_sys)
    begin
        cs_s1_reg <= cs_n;
        cs_s2_reg <= cs_s1_reg;
        strap_s1_reg <= addr_width_powerup_default;
        strap_s2_reg <= strap_s1_reg;
        if (!resetn)
        begin
            cs_prev_reg <= 1'b1;
        end
        else
        begin
            cs_prev_reg <= cs_s2_reg;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            upper_reg <= UPPER_RESET;
            sr1_reg <= SR_RESET;
            sr2_reg <= SR_RESET;
            sr3_reg <= SR_RESET;
            sr3_reg[SR3_ADDR_WIDTH] <= strap_s2_reg;
            sr3_reg[SR3_PWRUP_DEFAULT] <= strap_s2_reg;
            wel_reg <= 1'b0;
            vwe_reg <= 1'b0;
            pd_reg <= 1'b0;
            rst_en_reg <= 1'b0;
            lock_reg <= '1;
            busy_cnt_reg <= 16'd0;
            cmd_valid_reg <= 1'b0;
            cmd_reg <= '0;
        end
        else
        begin
            cmd_valid_reg <= arr_go;
            if (busy)
            begin
                busy_cnt_reg <= busy_cnt_reg - 16'd1;
            end
            if (arr_go || sr_go)
            begin
                busy_cnt_reg <= 16'(BUSY_CYCLES);
                wel_reg <= 1'b0;
                vwe_reg <= 1'b0;
            end
            if (arr_go)
            begin
                cmd_reg <= '{kind: kind, addr: full_addr};
            end
            if (sr_go && op == OP_WRSR1)
            begin
                sr1_reg <= (sr1_reg & ~SR_WR_MASK1) | (frame_reg.last_data & SR_WR_MASK1);
            end
            if (sr_go && op == OP_WRSR2)
            begin
                sr2_reg <= frame_reg.last_data;
            end
            if (sr_go && op == OP_WRSR3)
            begin
                sr3_reg <= (sr3_reg & ~SR_WR_MASK3) | (frame_reg.last_data & SR_WR_MASK3);
            end
            if (single && op == OP_WREN)
            begin
                wel_reg <= 1'b1;
            end
            if (single && op == OP_VSR_WREN)
            begin
                vwe_reg <= 1'b1;
            end
            if (single && op == OP_WRDI)
            begin
                wel_reg <= 1'b0;
                vwe_reg <= 1'b0;
            end
            if (single && op == OP_DEV_ID)
            begin
                pd_reg <= 1'b0;
            end
            if (single && op == OP_PWR_DOWN)
            begin
                pd_reg <= 1'b1;
            end
            if (single && op == OP_ENTER4)
            begin
                sr3_reg[SR3_ADDR_WIDTH] <= 1'b1;
            end
            if (single && op == OP_EXIT4)
            begin
                sr3_reg[SR3_ADDR_WIDTH] <= 1'b0;
            end
            if (single && wel_reg && op == OP_LOCK_ALL)
            begin
                lock_reg <= '1;
            end
            if (single && wel_reg && op == OP_UNLOCK_ALL)
            begin
                lock_reg <= '0;
            end
            if (accept)
            begin
                rst_en_reg <= single && (op == OP_RST_EN);
            end
            if (wr_ok && op == OP_WR_UPPER && nbytes == 4'd2)
            begin
                upper_reg <= frame_reg.last_data;
            end
            if (upper_load)
            begin
                upper_reg <= frame_reg.first_addr;
            end
            if (soft_rst)
            begin
                upper_reg <= UPPER_RESET;
                wel_reg <= 1'b0;
                vwe_reg <= 1'b0;
                sr3_reg[SR3_ADDR_WIDTH] <= sr3_reg[SR3_PWRUP_DEFAULT];
            end
        end
    end

    assign array_cmd_valid = cmd_valid_reg;
    assign array_cmd = cmd_reg;
    assign upper_address_byte = upper_reg;
endmodule

// File: verif/sfcfe_monitor.sv
// Port-level concurrent checks for the command front end
`timescale 1ns/10ps
module sfcfe_monitor
    import sfcfe_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic serial_data_out_oe,
    input wire logic [31:0] array_rd_addr,
    input wire logic prog_byte_valid,
    input wire logic array_cmd_valid,
    input wire sfcfe_array_cmd_t array_cmd,
    input wire logic [7:0] upper_address_byte
);
    // Busy window after a commit, one cycle short for slack
    logic [7:0] gap_reg;
    sequence s_byte_gap;
        !prog_byte_valid [*7];
    endsequence
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            gap_reg <= 8'h00;
        else if (array_cmd_valid)
            gap_reg <= 8'hc7;
        else if (gap_reg != 8'h00)
            gap_reg <= gap_reg - 8'h01;
    end
    chk_idle_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
        cs_n |-> !serial_data_out_oe && !prog_byte_valid) else $error("active while deselected");
    chk_busy_filter: assert property (@(posedge clk_sys) disable iff (!resetn)
        array_cmd_valid |-> gap_reg == 8'h00) else $error("commit during busy window");
    chk_commit_at_end: assert property (@(posedge clk_sys) disable iff (!resetn)
        array_cmd_valid |-> $past(cs_n) && $past(cs_n, 3)) else $error("commit inside frame");
    chk_upper_cleared: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(resetn) |-> upper_address_byte == 8'h00) else $error("upper byte not cleared");
    chk_upper_at_end: assert property (@(posedge clk_sys) disable iff (!resetn)
        $changed(upper_address_byte) |-> cs_n && $past(cs_n, 2)) else $error("upper byte early");
    chk_cmd_holds: assert property (@(posedge clk_sys) disable iff (!resetn)
        !array_cmd_valid |-> $stable(array_cmd)) else $error("command word moved");
    chk_byte_spacing: assert property (@(posedge sck) disable iff (cs_n)
        prog_byte_valid |=> s_byte_gap) else $error("program bytes closer than eight bits");
    chk_rd_addr_step: assert property (@(posedge sck) disable iff (cs_n)
        serial_data_out_oe && $past(serial_data_out_oe) && $changed(array_rd_addr)
        |-> array_rd_addr == $past(array_rd_addr) + 32'h1) else $error("read address skipped");
endmodule
bind sfcfe_top sfcfe_monitor i_mon (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .cs_n(cs_n),
    .sck(sck),
    .serial_data_out_oe(serial_data_out_oe),
    .array_rd_addr(array_rd_addr),
    .prog_byte_valid(prog_byte_valid),
    .array_cmd_valid(array_cmd_valid),
    .array_cmd(array_cmd),
    .upper_address_byte(upper_address_byte)
);

// File: verif/sfcfe_host_model.sv
// Host serial controller model: chip select, serial clock and data out
`timescale 1ns/10ps
module sfcfe_host_model (
    output logic cs_n,
    output logic sck,
    output logic sdi,
    input wire logic sdo
);
    initial
    begin
        cs_n = 1'b0;
        sck = 1'b0;
        sdi = 1'b1;
        #1 cs_n = 1'b1;
    end
    task automatic xfer(input logic [127:0] tx, input int n, output logic [127:0] rx);
        rx = '0;
        #1.3 cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            sdi = tx[i];
            #24 sck = 1'b1;
            rx = {rx[126:0], sdo};
            #24 sck = 1'b0;
        end
        #12 cs_n = 1'b1;
        sdi = ~sdi;
        #60;
    endtask
endmodule

// File: verif/test_serial_flash_command_front_end.sv
// Self-checking bench for the serial flash command front end
`timescale 1ns/10ps
module test_serial_flash_command_front_end;
    import sfcfe_pkg::*;
    // Arbitrary identifier value
    localparam logic [63:0] UID = 64'h3141_5926_5358_9793;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic strap = 1'b0;
    logic [7:0] arr_data = 8'h00;
    wire cs_n, sck, sdi, sdo_raw, sdo_oe, sdo, cmd_valid, pbv;
    wire [31:0] rd_addr;
    wire [7:0] pbyte, upper;
    sfcfe_array_cmd_t cmd;
    sfcfe_array_cmd_t q_cmd[$];
    logic [7:0] q_pb[$];
    logic [7:0] er_op[7] = '{8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60, 8'h21, 8'hdc};
    sfcfe_kind_t er_k[7] = '{SFCFE_ERASE_4K, SFCFE_ERASE_32K, SFCFE_ERASE_64K,
        SFCFE_ERASE_ALL, SFCFE_ERASE_ALL, SFCFE_ERASE_4K, SFCFE_ERASE_64K};
    int err_count = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [127:0] rx;
    logic [23:0] a;
    logic [7:0] d0, d1;
    assign sdo = sdo_oe ? sdo_raw : 1'bz;
    always #2.5 clk_sys = ~clk_sys;
    sfcfe_host_model i_host (.cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo(sdo));
    sfcfe_top #(.UNIQUE_ID(UID)) i_dut (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .cs_n(cs_n),
        .sck(sck),
        .serial_data_in(sdi),
        .serial_data_out(sdo_raw),
        .serial_data_out_oe(sdo_oe),
        .addr_width_powerup_default(strap),
        .array_rd_addr(rd_addr),
        .array_rd_data(arr_data),
        .prog_byte_valid(pbv),
        .prog_byte(pbyte),
        .array_cmd_valid(cmd_valid),
        .array_cmd(cmd),
        .upper_address_byte(upper)
    );
    function automatic logic [7:0] arr_byte(input logic [31:0] x);
        return x[7:0] ^ x[23:16] ^ x[31:24];
    endfunction
    // Array model, settled before the next falling edge
    always @(posedge clk_sys)
        arr_data <= arr_byte(rd_addr);
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Chip erase has no address to compare
    task automatic cmp_cmd(input sfcfe_array_cmd_t got, input sfcfe_array_cmd_t exp);
        n_tests++;
        if (exp.kind == SFCFE_ERASE_ALL)
            got.addr = exp.addr;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    always @(posedge clk_sys)
        if (cmd_valid === 1'b1)
            cmp_cmd(cmd, q_cmd.size() != 0 ? q_cmd.pop_front() : sfcfe_array_cmd_t'('1));
    always @(negedge sck)
        if (pbv === 1'b1)
            cmp(64'(pbyte), q_pb.size() != 0 ? 64'(q_pb.pop_front()) : 64'hx);
    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            err_count++;
            end_of_test();
        end
    end
    task automatic fr(input logic [127:0] tx, input int n);
        i_host.xfer(tx, n, rx);
    endtask
    task automatic do_reset(input logic s);
        @(posedge clk_sys);
        resetn <= 1'b0;
        strap <= s;
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic status(input logic [7:0] op, input logic [7:0] exp);
        fr(128'({op, 8'h00}), 16);
        cmp(64'(rx[7:0]), 64'(exp));
    endtask
    task automatic wait_idle();
        repeat (8)
        begin
            fr(128'({OP_RDSR1, 8'h00}), 16);
            if (rx[0] === 1'b0)
                break;
        end
    endtask
    initial
    begin
        void'($urandom(58));
        do_reset(1'b0);
        cmp(64'(upper), 64'h0);
        status(OP_RDSR1, 8'h00);
        fr(128'(OP_WREN), 8);
        fr(128'(OP_PWR_DOWN), 8);
        fr(128'(OP_WRDI), 8);
        fr(128'(OP_DEV_ID), 8);
        status(OP_RDSR1, 8'h02);
        fr(128'(OP_WRDI), 8);
        status(OP_RDSR1, 8'h00);
        fr(128'({OP_JEDEC, 24'h0}), 32);
        cmp(64'(rx[23:0]), 64'h5a1234);
        fr(128'({OP_DEV_ID, 32'h0}), 40);
        cmp(64'(rx[7:0]), 64'h3c);
        for (int k = 0; k < 6; k += 2)
        begin
            fr(128'({8'h90 + 8'(k), 24'(k / 2), 16'h0}), 48);
            cmp(64'(rx[15:0]), (k == 2) ? 64'h3c5a : 64'h5a3c);
        end
        fr(128'({OP_UID, 96'h0}), 104);
        cmp(rx[63:0], UID);
        a = 24'($urandom());
        fr(128'({OP_READ3, a, 16'h0}), 48);
        cmp(64'(rx[15:0]), 64'({arr_byte({8'h00, a}), arr_byte({8'h00, a} + 32'h1)}));
        fr(128'({OP_FREAD3, a, 16'h0}), 48);
        cmp(64'(rx[7:0]), 64'(arr_byte({8'h00, a})));
        fr(128'({OP_READ3, a, 3'h0}), 35);
        status(OP_RDSR1, 8'h00);
        for (int k = 0; k < 2; k++)
        begin
            a = 24'($urandom());
            d0 = 8'($urandom());
            d1 = 8'($urandom());
            q_cmd.push_back('{SFCFE_PROG, {8'h00, a}});
            q_pb.push_back(d0);
            q_pb.push_back(d1);
            fr(128'(OP_WREN), 8);
            if (k == 0)
                fr(128'({OP_PROG3, a, d0, d1}), 48);
            else
                fr(128'({OP_PROG4, 8'h00, a, d0, d1}), 56);
            wait_idle();
        end
        foreach (er_op[k])
        begin
            a = 24'($urandom());
            q_cmd.push_back('{er_k[k], {8'h00, a}});
            fr(128'(OP_WREN), 8);
            if (k < 3)
                fr(128'({er_op[k], a}), 32);
            else if (k < 5)
                fr(128'(er_op[k]), 8);
            else
                fr(128'({er_op[k], 8'h00, a}), 40);
            fr(128'(OP_WREN), 8);
            wait_idle();
            cmp(64'(rx[7:0]), 64'h0);
        end
        fr(128'(OP_WREN), 8);
        fr(128'({OP_SE3, a[23:1]}), 31);
        status(OP_RDSR1, 8'h02);
        fr(128'({OP_READ4, 8'h01, a, 8'h0}), 48);
        cmp(64'(rx[7:0]), 64'(arr_byte({8'h01, a})));
        cmp(64'(upper), 64'h01);
        fr(128'({OP_READ3, a, 8'h0}), 40);
        cmp(64'(rx[7:0]), 64'(arr_byte({8'h01, a})));
        fr(128'(OP_RST_EN), 8);
        fr(128'(OP_RST), 8);
        cmp(64'(upper), 64'h0);
        fr(128'(OP_VSR_WREN), 8);
        fr(128'({OP_WRSR3, 8'h04}), 16);
        wait_idle();
        fr(128'(OP_WREN), 8);
        fr(128'({OP_SE3, a}), 32);
        wait_idle();
        status(OP_RDSR3, 8'h04);
        fr(128'(OP_ENTER4), 8);
        fr(128'({OP_READ3, 8'h02, a, 8'h0}), 48);
        cmp(64'(rx[7:0]), 64'(arr_byte({8'h02, a})));
        cmp(64'(upper), 64'h02);
        do_reset(1'b1);
        cmp(64'(upper), 64'h0);
        status(OP_RDSR3, 8'h03);
        fr(128'({OP_READ3, 8'h01, a, 8'h0}), 48);
        cmp(64'(rx[7:0]), 64'(arr_byte({8'h01, a})));
        cmp(64'(q_cmd.size() + q_pb.size()), 64'h0);
        end_of_test();
    end
endmodule
